// ==== dcrc_pkg.sv ====
// Package for the core run-control register bank: offsets, fields, resets.
// Assumes a 16-bit register port addressed by register index.
package dcrc_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam logic [15:0] ADDR_ABORT = 16'hF403;
    localparam logic [15:0] ADDR_ENTRY = 16'hF404;
    localparam logic [15:0] ADDR_STATE = 16'hF405;
    localparam logic [15:0] ADDR_FCLR = 16'hF421;
    localparam logic [15:0] ADDR_START = 16'hF402;
    localparam logic [15:0] ADDR_HALT = 16'hF400;
    localparam logic [15:0] ADDR_FLAG = 16'hF427;
    localparam logic [15:0] ADDR_IRQ_STAT = 16'hF4E0;
    localparam logic [15:0] ADDR_IRQ_MASK = 16'hF4E1;
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic [15:0] RST_ENTRY = 16'h0000;
    localparam int unsigned CTL_BIT = 0;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_STOP = 0;
    localparam int unsigned IRQ_START = 1;
    localparam int unsigned IRQ_FAULT = 2;
    typedef enum logic [2:0] {
        DCRC_ST_STOPPED = 3'h0,
        DCRC_ST_RUNNING = 3'h1,
        DCRC_ST_PAUSED = 3'h2,
        DCRC_ST_SLEEP = 3'h3,
        DCRC_ST_STALLED = 3'h4
    } dcrc_state_t;
endpackage : dcrc_pkg

// ==== dcrc_run_ctrl.sv ====
// Run-control and status registers of the processing core.
// Assumes the core reports pause, sleep, stall and frame-end on core_clk_i.
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module dcrc_run_ctrl
    import dcrc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [DATA_W-1:0] reg_rdata_o,
    input wire logic core_pause_i,
    input wire logic core_sleep_i,
    input wire logic core_stall_i,
    input wire logic frame_done_i,
    input wire logic fault_src_i,
    output logic core_run_o,
    output logic core_kill_o,
    output logic pc_load_o,
    output logic [15:0] pc_value_o,
    output logic irq_gate_o,
    output logic fault_reset_o,
    output logic fault_flag_o,
    output logic irq_o
);
    logic [15:0] abort_q;
    logic [15:0] entry_q;
    logic [15:0] fclr_q;
    logic [15:0] start_q;
    logic [15:0] halt_q;
    logic running_q;
    logic halt_pend_q;
    logic fault_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [DATA_W-1:0] rdata_q;
    logic pc_load_q;
    logic [15:0] pc_q;
    logic kill_q;
    logic frst_q;
    logic irq_q;
    logic [2:0] state_live;
    logic abort_rise;
    logic start_rise;
    logic fclr_rise;
    logic halt_rise;
    logic start_ok;
    logic stop_evt;
    logic [IRQ_W-1:0] irq_evt;

    function automatic logic is_wr(input logic [15:0] a, input logic [15:0] t);
        return reg_wr_i && (a == t);
    endfunction : is_wr

    // Rising edge of bit 0 caused by a write in this cycle
    function automatic logic rise(input logic [15:0] a, input logic [15:0] q);
        return is_wr(reg_addr_i, a) && reg_wdata_i[CTL_BIT] && !q[CTL_BIT];
    endfunction : rise

    assign abort_rise = rise(ADDR_ABORT, abort_q);
    assign start_rise = rise(ADDR_START, start_q);
    assign fclr_rise = rise(ADDR_FCLR, fclr_q);
    assign halt_rise = rise(ADDR_HALT, halt_q);
    // Start refused while abort held or being set
    assign start_ok = start_rise && !abort_q[CTL_BIT] && !abort_rise;
    assign stop_evt = running_q && (abort_rise || (halt_pend_q && frame_done_i));

    always_comb begin
        state_live = DCRC_ST_STOPPED;
        if (running_q) begin
            if (core_stall_i) begin
                state_live = DCRC_ST_STALLED;
            end else if (core_pause_i) begin
                state_live = DCRC_ST_PAUSED;
            end else if (core_sleep_i) begin
                state_live = DCRC_ST_SLEEP;
            end else begin
                state_live = DCRC_ST_RUNNING;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            abort_q <= RST_WORD;
            entry_q <= RST_ENTRY;
            fclr_q <= RST_WORD;
            start_q <= RST_WORD;
            halt_q <= RST_WORD;
        end else if (clk_en_i) begin
            if (is_wr(reg_addr_i, ADDR_ABORT)) begin
                abort_q <= reg_wdata_i;
            end
            if (is_wr(reg_addr_i, ADDR_ENTRY)) begin
                entry_q <= reg_wdata_i;
            end
            if (is_wr(reg_addr_i, ADDR_FCLR)) begin
                fclr_q <= reg_wdata_i;
            end
            if (is_wr(reg_addr_i, ADDR_START)) begin
                start_q <= reg_wdata_i;
            end
            if (is_wr(reg_addr_i, ADDR_HALT)) begin
                halt_q <= reg_wdata_i;
            end
        end
    end

    // Run state: abort wins over everything, clearing abort never restarts
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            running_q <= 1'b0;
            halt_pend_q <= 1'b0;
        end else if (clk_en_i) begin
            if (abort_rise || abort_q[CTL_BIT]) begin
                running_q <= 1'b0;
                halt_pend_q <= 1'b0;
            end else if (start_ok) begin
                running_q <= 1'b1;
                halt_pend_q <= 1'b0;
            end else if (halt_pend_q && frame_done_i) begin
                running_q <= 1'b0;
                halt_pend_q <= 1'b0;
            end else if (halt_rise && running_q) begin
                halt_pend_q <= 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            pc_load_q <= 1'b0;
            pc_q <= RST_ENTRY;
            kill_q <= 1'b0;
        end else if (clk_en_i) begin
            pc_load_q <= start_ok;
            if (start_ok) begin
                pc_q <= entry_q;
            end
            // Follows the abort bit as written, so it drops with the clear
            if (is_wr(reg_addr_i, ADDR_ABORT)) begin
                kill_q <= reg_wdata_i[CTL_BIT];
            end else begin
                kill_q <= abort_q[CTL_BIT];
            end
        end
    end

    // Fault flag: a new fault in the clearing cycle wins
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            fault_q <= 1'b0;
            frst_q <= 1'b0;
        end else if (clk_en_i) begin
            frst_q <= fclr_rise;
            if (fault_src_i) begin
                fault_q <= 1'b1;
            end else if (fclr_rise) begin
                fault_q <= 1'b0;
            end
        end
    end

    assign irq_evt = {fault_src_i && !fault_q, start_ok, stop_evt};

    // Sticky status cleared by read; a same-cycle event wins
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            irq_stat_q <= '0;
            irq_mask_q <= '0;
            irq_q <= 1'b0;
        end else if (clk_en_i) begin
            if (reg_rd_i && reg_addr_i == ADDR_IRQ_STAT) begin
                irq_stat_q <= irq_evt;
            end else begin
                irq_stat_q <= irq_stat_q | irq_evt;
            end
            if (is_wr(reg_addr_i, ADDR_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata_i[IRQ_W-1:0];
            end
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            rdata_q <= '0;
        end else if (clk_en_i) begin
            rdata_q <= '0;
            if (reg_rd_i) begin
                unique case (reg_addr_i)
                    ADDR_ABORT: rdata_q <= abort_q;
                    ADDR_ENTRY: rdata_q <= entry_q;
                    ADDR_STATE: rdata_q <= {13'h0000, state_live};
                    ADDR_FCLR: rdata_q <= fclr_q;
                    ADDR_START: rdata_q <= start_q;
                    ADDR_HALT: rdata_q <= halt_q;
                    ADDR_FLAG: rdata_q <= {15'h0000, fault_q};
                    ADDR_IRQ_STAT: rdata_q <= {13'h0000, irq_stat_q};
                    ADDR_IRQ_MASK: rdata_q <= {13'h0000, irq_mask_q};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign reg_rdata_o = rdata_q;
    assign core_run_o = running_q;
    assign core_kill_o = kill_q;
    assign pc_load_o = pc_load_q;
    assign pc_value_o = pc_q;
    assign irq_gate_o = halt_q[CTL_BIT];
    assign fault_reset_o = frst_q;
    assign fault_flag_o = fault_q;
    assign irq_o = irq_q;
endmodule : dcrc_run_ctrl
`default_nettype wire

// ==== dcrc_run_ctrl_checker.sv ====
// Port assertions for the run-control register bank.
// Assumes clk_en_i stays high; bound below to dcrc_run_ctrl.
`timescale 1ns/1ps
`default_nettype none
module dcrc_run_ctrl_checker
    import dcrc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic core_pause_i,
    input wire logic core_sleep_i,
    input wire logic core_stall_i,
    input wire logic fault_src_i,
    input wire logic core_run_o,
    input wire logic core_kill_o,
    input wire logic pc_load_o,
    input wire logic fault_reset_o,
    input wire logic fault_flag_o
);
    logic start_q;
    logic fclr_q;
    wire logic wd = reg_wdata_i[CTL_BIT];
    wire logic st_w = reg_wr_i && reg_addr_i == ADDR_START;
    wire logic fc_w = reg_wr_i && reg_addr_i == ADDR_FCLR;
    wire logic [2:0] exp_st = !core_run_o ? 3'h0 : core_stall_i ? 3'h4 :
        core_pause_i ? 3'h2 : core_sleep_i ? 3'h3 : 3'h1;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            start_q <= 1'h0;
            fclr_q <= 1'h0;
        end else if (st_w) begin
            start_q <= wd;
        end else if (fc_w) begin
            fclr_q <= wd;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_ABORT_STOP: assert property (
        reg_wr_i && reg_addr_i == ADDR_ABORT && wd |=> core_kill_o && !core_run_o)
        else $error("abort did not stop core");
    AST_KILL_HOLD: assert property (
        core_kill_o |-> !core_run_o) else $error("core runs while aborted");
    AST_KILL_REFUSE: assert property (
        core_kill_o |=> !pc_load_o) else $error("start taken while aborted");
    AST_ABORT_CLR: assert property (
        $fell(core_kill_o) |-> !core_run_o) else $error("abort clear restarted");
    AST_START: assert property (
        st_w && wd && !start_q && !core_kill_o |=> pc_load_o && core_run_o)
        else $error("start rise not taken");
    AST_START_FALL: assert property (
        st_w && !wd |=> !pc_load_o) else $error("start fall loaded pc");
    AST_STATE_RD: assert property (
        reg_rd_i && reg_addr_i == ADDR_STATE |=> reg_rdata_o[2:0] == $past(exp_st))
        else $error("state readback wrong");
    AST_FCLR: assert property (
        fc_w && wd && !fclr_q && !fault_src_i |=> fault_reset_o && !fault_flag_o)
        else $error("fault clear edge ignored");
    AST_STICKY: assert property (
        (fault_src_i || fault_flag_o) && !(fc_w && wd && !fclr_q) |=> fault_flag_o)
        else $error("fault flag lost");
endmodule : dcrc_run_ctrl_checker
bind dcrc_run_ctrl dcrc_run_ctrl_checker u_chk(.core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .core_pause_i(core_pause_i), .core_sleep_i(core_sleep_i),
    .core_stall_i(core_stall_i), .fault_src_i(fault_src_i),
    .core_run_o(core_run_o), .core_kill_o(core_kill_o), .pc_load_o(pc_load_o),
    .fault_reset_o(fault_reset_o), .fault_flag_o(fault_flag_o));
`default_nettype wire

// ==== testbench.sv ====
// Register-level test of the run-control bank.
// Assumes the checker file is compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp=%h got=%h", n, e, g); end end
module testbench;
    import dcrc_pkg::*;
    logic core_clk_i = 1'h0, reset_n_i = 1'h0, wr = 1'h0, rd = 1'h0;
    logic pa = 1'h0, sl = 1'h0, stl = 1'h0, fd = 1'h0, fs = 1'h0;
    logic [15:0] ad = 16'h0000, wdt = 16'h0000, rdt, pcv, rv;
    logic run, kill, pcl, gate, frst, flag, irq;
    int error_cnt = 0, n_tests = 0;
    logic [15:0] regs [5] = '{ADDR_ABORT, ADDR_ENTRY, ADDR_STATE, ADDR_FCLR, 16'hF410};
    logic [2:0] sti [4] = '{3'h2, 3'h1, 3'h4, 3'h6};
    logic [15:0] ste [4] = '{16'h0002, 16'h0003, 16'h0004, 16'h0004};
    always #12.5 core_clk_i = ~core_clk_i;
    dcrc_run_ctrl u_dut(.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .clk_en_i(1'h1), .reg_addr_i(ad), .reg_wdata_i(wdt), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdt), .core_pause_i(pa), .core_sleep_i(sl),
        .core_stall_i(stl), .frame_done_i(fd), .fault_src_i(fs),
        .core_run_o(run), .core_kill_o(kill), .pc_load_o(pcl), .pc_value_o(pcv),
        .irq_gate_o(gate), .fault_reset_o(frst), .fault_flag_o(flag), .irq_o(irq));
    task step;
        @(posedge core_clk_i);
        #1;
    endtask : step
    task wrr(input logic [15:0] a, input logic [15:0] d);
        @(posedge core_clk_i);
        ad <= a;
        wdt <= d;
        wr <= 1'h1;
        @(posedge core_clk_i);
        wr <= 1'h0;
        #1;
    endtask : wrr
    task rdchk(input logic [15:0] a, input logic [15:0] e);
        @(posedge core_clk_i);
        ad <= a;
        rd <= 1'h1;
        @(posedge core_clk_i);
        rd <= 1'h0;
        #1;
        `CHK("reg read", e, rdt)
    endtask : rdchk
    task fault;
        @(posedge core_clk_i);
        fs <= 1'h1;
        @(posedge core_clk_i);
        fs <= 1'h0;
        #1;
    endtask : fault
    task summarize;
        $display("errors %0d of %0d checks", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (2000) @(posedge core_clk_i);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (6) @(posedge core_clk_i);
        reset_n_i <= 1'h1;
        foreach (regs[i]) rdchk(regs[i], 16'h0000);
        wrr(ADDR_ENTRY, 16'hA5C3);
        rdchk(ADDR_ENTRY, 16'hA5C3);
        wrr(ADDR_STATE, 16'h0007);
        rdchk(ADDR_STATE, 16'h0000);
        wrr(ADDR_START, 16'h0001);
        `CHK("pc_value", 16'hA5C3, pcv)
        `CHK("pc_load", 1'h1, pcl)
        rdchk(ADDR_STATE, 16'h0001);
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk_i);
            {stl, pa, sl} <= sti[i];
            rdchk(ADDR_STATE, ste[i]);
        end
        @(posedge core_clk_i);
        {stl, pa, sl} <= 3'h0;
        wrr(ADDR_START, 16'h0000);
        `CHK("run", 1'h1, run)
        wrr(ADDR_ABORT, 16'h0001);
        `CHK("kill", 1'h1, kill)
        rdchk(ADDR_STATE, 16'h0000);
        wrr(ADDR_START, 16'h0001);
        `CHK("pc_load", 1'h0, pcl)
        wrr(ADDR_START, 16'h0000);
        wrr(ADDR_ABORT, 16'h0000);
        `CHK("run", 1'h0, run | kill)
        wrr(ADDR_START, 16'h0001);
        `CHK("run", 1'h1, run)
        rdchk(ADDR_IRQ_STAT, 16'h0003);
        wrr(ADDR_HALT, 16'h0001);
        `CHK("gate", 1'h1, gate & run)
        @(posedge core_clk_i);
        fd <= 1'h1;
        @(posedge core_clk_i);
        fd <= 1'h0;
        step();
        `CHK("run", 1'h0, run | irq)
        wrr(ADDR_IRQ_MASK, 16'h0007);
        step();
        `CHK("irq", 1'h1, irq)
        rdchk(ADDR_IRQ_STAT, 16'h0001);
        step();
        `CHK("irq", 1'h0, irq)
        fault();
        rdchk(ADDR_FLAG, 16'h0001);
        wrr(ADDR_FCLR, 16'h0001);
        `CHK("fault_clear", 2'h2, {frst, flag})
        fault();
        wrr(ADDR_FCLR, 16'h0001);
        `CHK("flag", 1'h1, flag)
        wrr(ADDR_FCLR, 16'h0000);
        wrr(ADDR_FCLR, 16'h0001);
        `CHK("flag", 1'h0, flag)
        summarize();
    end
endmodule : testbench
`default_nettype wire
